/* strap_cfg_pkg.sv */
// constants for the global strap and configuration block
// assumes a 100 MHz pclk and an apb register port
package strap_cfg_pkg;
	localparam logic [11:0] addr_status = 12'h000;
	localparam logic [11:0] addr_control = 12'h004;
	localparam logic [11:0] addr_port0 = 12'h008;
	localparam logic [11:0] addr_port1 = 12'h00c;
	localparam int slew_lsb = 10;
	localparam int slew_msb = 11;
	localparam int ctl_reset_bit = 15;
	localparam int ctl_fiber0_bit = 0;
	localparam int ctl_fiber1_bit = 1;
	localparam logic [31:0] control_reset = 32'h0000_0000;
	localparam int stat_link_bit = 0;
	localparam int stat_speed_bit = 1;
	localparam int stat_duplex_bit = 2;
	localparam int stat_act_bit = 3;
	localparam int stat_col_bit = 4;
	localparam int stat_rx_bit = 5;
	localparam int stat_tx_bit = 6;
	localparam int stat_iso_bit = 7;
	localparam int blink_ns = 50000000;
	localparam int clk_ns = 10;
	localparam int blink_cycles = blink_ns / clk_ns;
endpackage

/* sync2.sv */
// two-flop synchroniser for a bus of pin levels
// assumes inputs are asynchronous to clk
module sync2 #(
	parameter int width = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [width-1:0] async_in,
	output logic [width-1:0] sync_out
);
	logic [width-1:0] meta_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // sync2

/* phy_global_strap_config.sv */
// global strap capture, address assignment, led schemes and fiber routing
// assumes straps and status come from pins or other clocks, apb on pclk
// Summary of operation
// - the slew field 27.11:10 loads from the two slew straps at power-on, shared by both ports.
// - address bits 4..1 of port 0 come from the four address straps.
// - address bit 0 is internal so port 1 answers one above port 0.
// - the two led select inputs choose one of four led schemes, shared by both ports.
// - in fiber mode each port's signal detect gives its signal quality.
// - in fiber mode pair b transmits and pair a receives.
//
// Implementation choices: the register addresses and register access over APB.
module phy_global_strap_config #(
	parameter int blink_cycles = strap_cfg_pkg::blink_cycles
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_slope_select_lo,
	input wire logic tx_slope_select_hi,
	input wire logic phy_addr_strap_bit4,
	input wire logic phy_addr_strap_bit3,
	input wire logic phy_addr_strap_bit2,
	input wire logic phy_addr_strap_bit1,
	input wire logic led_scheme_select_a,
	input wire logic led_scheme_select_b,
	input wire logic fiber_signal_detect_port0,
	input wire logic fiber_signal_detect_port1,
	input wire logic [1:0] test_pins,
	input wire logic [1:0] port_link,
	input wire logic [1:0] port_speed,
	input wire logic [1:0] port_duplex,
	input wire logic [1:0] port_activity,
	input wire logic [1:0] port_collision,
	input wire logic [1:0] port_receive,
	input wire logic [1:0] port_transmit,
	input wire logic [1:0] port_isolate,
	output logic [1:0] port_led_one,
	output logic [1:0] port_led_two,
	output logic [1:0] port_led_three,
	output logic [1:0] slew_rate,
	output logic [4:0] phy_addr_port0,
	output logic [4:0] phy_addr_port1,
	output logic [1:0] signal_quality,
	output logic [1:0] pair_b_is_transmitter,
	output logic core_reset_n,
	output logic test_mode
);
	localparam int nin = 27;
	logic [nin-1:0] raw;
	logic [nin-1:0] syn;
	logic strap_done_q;
	logic [31:0] control_q;
	logic [1:0] slew_q;
	logic [3:0] addr_q;
	logic [31:0] blink_cnt_q;
	logic blink_q;
	logic [1:0] led_sel;

	assign raw = {tx_slope_select_hi, tx_slope_select_lo, phy_addr_strap_bit4,
		phy_addr_strap_bit3, phy_addr_strap_bit2, phy_addr_strap_bit1,
		led_scheme_select_b, led_scheme_select_a, fiber_signal_detect_port1,
		fiber_signal_detect_port0, test_pins, port_link, port_speed, port_duplex,
		port_activity, port_collision, port_receive, port_transmit, port_isolate[0]};

	sync2 #(
		.width(nin)
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.async_in(raw),
		.sync_out(syn)
	);

	logic [1:0] s_slew;
	logic [3:0] s_addr;
	logic [1:0] s_led;
	logic [1:0] s_sd;
	logic [1:0] s_test;
	logic [1:0] s_link, s_speed, s_dup, s_act, s_col, s_rx, s_tx;
	logic iso0_s;
	logic [1:0] iso_q;
	assign {s_slew, s_addr, s_led, s_sd, s_test, s_link, s_speed, s_dup, s_act, s_col,
		s_rx, s_tx, iso0_s} = syn;
	assign led_sel = s_led;

	// isolate of port 1 taken through its own pair of flops
	logic [1:0] iso1_meta_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iso1_meta_q <= 2'h0;
		end else begin
			iso1_meta_q <= {iso1_meta_q[0], port_isolate[1]};
		end
	end
	assign iso_q = {iso1_meta_q[1], iso0_s};

	// straps caught once after release, when synchronised values are settled
	logic [1:0] settle_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settle_q <= 2'h0;
			strap_done_q <= 1'b0;
			slew_q <= 2'h0;
			addr_q <= 4'h0;
		end else if (!strap_done_q) begin
			settle_q <= settle_q + 2'h1;
			if (settle_q == 2'h3) begin
				strap_done_q <= 1'b1;
				slew_q <= s_slew;
				addr_q <= s_addr;
			end
		end else if (psel && penable && pwrite && paddr == strap_cfg_pkg::addr_control) begin
			slew_q <= pwdata[strap_cfg_pkg::slew_msb:strap_cfg_pkg::slew_lsb];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slew_rate <= 2'h0;
			phy_addr_port0 <= 5'h00;
			phy_addr_port1 <= 5'h00;
		end else begin
			slew_rate <= slew_q;
			phy_addr_port0 <= {addr_q, 1'b0};
			phy_addr_port1 <= {addr_q, 1'b1};
		end
	end

	// control register; the self-clearing reset bit pulses the core reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_q <= strap_cfg_pkg::control_reset;
		end else if (psel && penable && pwrite && paddr == strap_cfg_pkg::addr_control) begin
			control_q <= pwdata;
		end else begin
			control_q[strap_cfg_pkg::ctl_reset_bit] <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset_n <= 1'b0;
			test_mode <= 1'b0;
		end else begin
			core_reset_n <= !control_q[strap_cfg_pkg::ctl_reset_bit] && strap_done_q;
			test_mode <= |s_test;
		end
	end

	logic [1:0] fiber;
	assign fiber = {control_q[strap_cfg_pkg::ctl_fiber1_bit],
		control_q[strap_cfg_pkg::ctl_fiber0_bit]};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			signal_quality <= 2'h0;
			pair_b_is_transmitter <= 2'h0;
		end else begin
			signal_quality <= fiber & s_sd;
			pair_b_is_transmitter <= fiber;
		end
	end

	// blink enable for the activity, isolate and collision schemes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b0;
		end else if (blink_cnt_q >= 32'(blink_cycles - 1)) begin
			blink_cnt_q <= 32'h0;
			blink_q <= !blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h1;
		end
	end

	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_led
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					port_led_one[p] <= 1'b0;
					port_led_two[p] <= 1'b0;
					port_led_three[p] <= 1'b0;
				end else begin
					unique case (led_sel)
						2'b00: begin
							port_led_one[p] <= s_speed[p];
							port_led_two[p] <= s_link[p];
							port_led_three[p] <= s_dup[p];
						end
						2'b01: begin
							port_led_one[p] <= s_speed[p];
							port_led_two[p] <= s_link[p] && !(s_act[p] && blink_q);
							port_led_three[p] <= s_dup[p] || (s_col[p] && blink_q);
						end
						2'b10: begin
							port_led_one[p] <= s_link[p];
							port_led_two[p] <= s_rx[p];
							port_led_three[p] <= s_tx[p];
						end
						2'b11: begin
							port_led_one[p] <= s_speed[p];
							port_led_two[p] <= s_link[p] || (iso_q[p] && blink_q);
							port_led_three[p] <= s_dup[p] || (s_col[p] && blink_q);
						end
					endcase
				end
			end
		end
	endgenerate

	// apb slave: zero wait states, unmapped addresses raise pslverr
	logic [31:0] status_word;
	assign status_word = {8'h00, iso_q, s_tx, s_rx, s_col, s_act, s_dup, s_speed, s_link,
		2'h0, s_sd, s_test, s_led};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			if (psel && !penable) begin
				unique case (paddr)
					strap_cfg_pkg::addr_status: prdata <= status_word;
					strap_cfg_pkg::addr_control: begin
						prdata <= control_q;
						prdata[strap_cfg_pkg::slew_msb:strap_cfg_pkg::slew_lsb] <= slew_q;
					end
					strap_cfg_pkg::addr_port0: prdata <= {27'h0, addr_q, 1'b0};
					strap_cfg_pkg::addr_port1: prdata <= {27'h0, addr_q, 1'b1};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule // phy_global_strap_config

/* strap_cfg_sva.sv */
// assertions on strap capture, address pairing, reset and led schemes
// assumes binding to phy_global_strap_config under its own port names
module strap_cfg_sva #(
	parameter int blink_cycles = strap_cfg_pkg::blink_cycles
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic led_scheme_select_a,
	input wire logic led_scheme_select_b,
	input wire logic [1:0] port_link,
	input wire logic [1:0] port_speed,
	input wire logic [1:0] port_duplex,
	input wire logic [1:0] port_receive,
	input wire logic [1:0] port_transmit,
	input wire logic [1:0] port_led_one,
	input wire logic [1:0] port_led_two,
	input wire logic [1:0] port_led_three,
	input wire logic [1:0] slew_rate,
	input wire logic [4:0] phy_addr_port0,
	input wire logic [4:0] phy_addr_port1,
	input wire logic [1:0] signal_quality,
	input wire logic [1:0] pair_b_is_transmitter,
	input wire logic core_reset_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire ctl_wr = psel && penable && pready && pwrite && paddr == strap_cfg_pkg::addr_control;
	sequence s_quiet;
		$stable({led_scheme_select_a, led_scheme_select_b, port_link, port_speed, port_duplex,
			port_receive, port_transmit})[*4];
	endsequence
	sequence s_scheme_lr;
		s_quiet ##0 (core_reset_n && !led_scheme_select_a && led_scheme_select_b);
	endsequence
	property p_addr_pair;
		core_reset_n |-> phy_addr_port1 == {phy_addr_port0[4:1], 1'b1} && !phy_addr_port0[0];
	endproperty
	a_addr_pair: assert property (p_addr_pair) else $error("port addresses not paired");
	property p_addr_hold;
		core_reset_n && $past(core_reset_n) |-> $stable(phy_addr_port0);
	endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved after capture");
	property p_core_hold;
		$rose(presetn) |-> !core_reset_n [*4];
	endproperty
	a_core_hold: assert property (p_core_hold) else $error("core left reset too soon");
	property p_soft;
		ctl_wr && pwdata[strap_cfg_pkg::ctl_reset_bit] |-> ##[1:2] !core_reset_n;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset ignored");
	property p_quality;
		(signal_quality & ~pair_b_is_transmitter) == 2'b00;
	endproperty
	a_quality: assert property (p_quality) else $error("quality outside fiber mode");
	property p_slew;
		core_reset_n && $past(core_reset_n) && !ctl_wr && !$past(ctl_wr) |=> $stable(slew_rate);
	endproperty
	a_slew: assert property (p_slew) else $error("slew changed without a write");
	property p_led_speed;
		s_quiet ##0 (core_reset_n && !(!led_scheme_select_a && led_scheme_select_b))
			|-> port_led_one == port_speed;
	endproperty
	a_led_speed: assert property (p_led_speed) else $error("led one not speed");
	property p_led_lr;
		s_scheme_lr |-> port_led_one == port_link && port_led_two == port_receive
			&& port_led_three == port_transmit;
	endproperty
	a_led_lr: assert property (p_led_lr) else $error("link receive scheme wrong");
	property p_led_plain;
		s_quiet ##0 (core_reset_n && !led_scheme_select_a && !led_scheme_select_b)
			|-> port_led_two == port_link && port_led_three == port_duplex;
	endproperty
	a_led_plain: assert property (p_led_plain) else $error("plain scheme wrong");
endmodule // strap_cfg_sva
bind phy_global_strap_config strap_cfg_sva #(.blink_cycles(blink_cycles)) strap_cfg_sva_inst (.*);

/* board_wiring.sv */
// board strap wiring model: straps, test pins and signal detect levels
// assumes the bench picks strap values before reset is released
module board_wiring (
	input wire logic [1:0] slew,
	input wire logic [3:0] addr,
	input wire logic [1:0] fiber,
	input wire logic [1:0] sd,
	output logic tx_slope_select_lo,
	output logic tx_slope_select_hi,
	output logic phy_addr_strap_bit4,
	output logic phy_addr_strap_bit3,
	output logic phy_addr_strap_bit2,
	output logic phy_addr_strap_bit1,
	output logic fiber_signal_detect_port0,
	output logic fiber_signal_detect_port1,
	output logic [1:0] test_pins
);
	assign {tx_slope_select_hi, tx_slope_select_lo} = slew;
	assign {phy_addr_strap_bit4, phy_addr_strap_bit3, phy_addr_strap_bit2, phy_addr_strap_bit1} = addr;
	assign test_pins = 2'b00;
	assign {fiber_signal_detect_port1, fiber_signal_detect_port0} = sd & fiber;
endmodule // board_wiring

/* test_phy_global_strap_config.sv */
// self-checking bench for the strap and configuration block
// assumes the board model and the checker compile alongside
module test_phy_global_strap_config;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic tx_slope_select_lo, tx_slope_select_hi, phy_addr_strap_bit4, phy_addr_strap_bit3;
	logic phy_addr_strap_bit2, phy_addr_strap_bit1, core_reset_n, test_mode;
	logic led_scheme_select_a = 0, led_scheme_select_b = 0;
	logic fiber_signal_detect_port0, fiber_signal_detect_port1;
	logic [1:0] test_pins, port_link = 0, port_speed = 0, port_duplex = 0, port_activity = 0;
	logic [1:0] port_collision = 0, port_receive = 0, port_transmit = 0, port_isolate = 0;
	logic [1:0] port_led_one, port_led_two, port_led_three, slew_rate, signal_quality;
	logic [1:0] pair_b_is_transmitter, slew = 0, fiber = 0, sd = 0;
	logic [4:0] phy_addr_port0, phy_addr_port1;
	logic [3:0] addr = 0;
	logic [5:0] led_and, led_or;
	integer seed = 32'h3433;
	int n_mismatch = 0, num_checks = 0;
	// one clock stands in for the master reference that all timing derives from
	always #5 pclk = ~pclk;
	board_wiring board_wiring_inst (.*);
	phy_global_strap_config #(.blink_cycles(4)) phy_global_strap_config_inst (.*);
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task power_on();
		{addr, slew} <= 6'($random(seed));
		presetn <= 0;
		repeat (12) @(posedge pclk);
		presetn <= 1;
		repeat (10) @(posedge pclk);
		chk("slew", slew_rate, slew);
		chk("phy_addr_internal_bit0", phy_addr_port0, {addr, 1'b0});
		chk("phy_addr_strap_bit1", phy_addr_port1, {addr, 1'b1});
		chk("test", test_mode, 0);
	endtask
	// expected led k for a given blink phase
	function logic [1:0] exp_led(input int k, input logic bl);
		logic [1:0] s;
		logic [1:0] b;
		s = {led_scheme_select_b, led_scheme_select_a};
		b = {2{bl}};
		if (k == 1) return s == 2'b10 ? port_link : port_speed;
		if (s == 2'b10) return k == 2 ? port_receive : port_transmit;
		if (k == 3) return port_duplex | (s[0] ? (port_collision & b) : 2'b00);
		if (s == 2'b01) return port_link & ~(port_activity & b);
		if (s == 2'b11) return port_link | (port_isolate & b);
		return port_link;
	endfunction
	task complete_run();
		if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#300000;
		n_mismatch++;
		complete_run();
	end
	initial begin
		power_on();
		apb(0, strap_cfg_pkg::addr_port1, 0);
		chk("phy_addr_strap_bit1 reg", rd[4:0], {addr, 1'b1});
		apb(1, 12'h010, 32'hffff_ffff);
		chk("unmapped", err, 1);
		for (int i = 0; i < 16; i++) begin
			fiber <= i[1:0];
			apb(1, strap_cfg_pkg::addr_control, {20'h0, slew, 8'h0, i[1:0]});
			{led_scheme_select_b, led_scheme_select_a} <= i[3:2];
			{sd, port_link, port_speed, port_duplex, port_activity, port_collision, port_receive,
				port_transmit, port_isolate} <= 18'($random(seed));
			repeat (4) @(posedge pclk);
			led_and = '1;
			led_or = '0;
			// eight samples span both blink phases
			repeat (8) begin
				@(posedge pclk);
				led_and &= {port_led_three, port_led_two, port_led_one};
				led_or |= {port_led_three, port_led_two, port_led_one};
			end
			chk("quality", signal_quality, sd & fiber);
			chk("pair b", pair_b_is_transmitter, fiber);
			chk("led1", port_led_one, exp_led(1, 1'b0));
			chk("led2 low", led_and[3:2], exp_led(2, 1'b0) & exp_led(2, 1'b1));
			chk("led2 high", led_or[3:2], exp_led(2, 1'b0) | exp_led(2, 1'b1));
			chk("led3 low", led_and[5:4], exp_led(3, 1'b0) & exp_led(3, 1'b1));
			chk("led3 high", led_or[5:4], exp_led(3, 1'b0) | exp_led(3, 1'b1));
		end
		apb(1, strap_cfg_pkg::addr_control, {16'h0, 4'h8, ~slew, 10'h0});
		repeat (2) @(posedge pclk);
		chk("core pulse", core_reset_n, 0);
		chk("slew written", slew_rate ^ slew, 2'b11);
		repeat (10) @(posedge pclk);
		chk("core run", core_reset_n, 1);
		chk("slew kept", slew_rate ^ slew, 2'b11);
		power_on();
		complete_run();
	end
endmodule // test_phy_global_strap_config
